/* pcls_pkg.sv */
// pcls_pkg: constants, encodings and state layout of the config-load sequencer.
// assumes a 50 MHz reference clock; all pin-side timing is derived from it.
`default_nettype none
package pcls_pkg;
  localparam int unsigned CLK_PERIOD_NS       = 20;
  // timing figures in their own units
  localparam int unsigned T_REQ_TO_LOW_NS     = 500;
  localparam int unsigned T_STATUS_MIN_US     = 45;
  localparam int unsigned T_STATUS_MAX_US     = 230;
  localparam int unsigned T_USER_MIN_US       = 300;
  localparam int unsigned T_USER_MAX_US       = 650;
  localparam int unsigned BCLK_PERIOD_MAX_NS  = 160;
  localparam int unsigned CD2CU_PERIODS       = 4;
  localparam int unsigned AS_HALF_NS          = 80;
  // derived cycle counts
  localparam int unsigned REQ_TO_LOW_CYC  = T_REQ_TO_LOW_NS / CLK_PERIOD_NS;
  localparam int unsigned STATUS_LOW_CYC  = (T_STATUS_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned USER_OSC_CYC    = (T_USER_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CD2CU_CYC       = (CD2CU_PERIODS * BCLK_PERIOD_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned AS_HALF_CYC     = AS_HALF_NS / CLK_PERIOD_NS;
  localparam logic [15:0] STATUS_LOW_LAST = 16'(STATUS_LOW_CYC - 1);
  localparam logic [15:0] CD2CU_LAST      = 16'(CD2CU_CYC - 1);
  localparam logic [3:0]  AS_HALF_LAST    = 4'(AS_HALF_CYC - 1);
  localparam logic [1:0]  DONE_FALL_EDGES = 2'h2;
  // test port instruction codes (arbitrary values)
  localparam logic [3:0]  IR_PROGRAM      = 4'h2;
  localparam logic [3:0]  IR_BYPASS       = 4'hF;
  localparam logic [3:0]  IR_CAPTURE      = 4'h1;

  typedef enum logic [1:0] {
    PCLS_PARALLEL = 2'h0,
    PCLS_PASSIVE  = 2'h1,
    PCLS_ACTIVE   = 2'h2,
    PCLS_RSVD     = 2'h3
  } pcls_scheme_t;

  typedef enum logic [3:0] {
    PH_POR   = 4'h0,
    PH_RESET = 4'h1,
    PH_LOAD  = 4'h2,
    PH_DONE  = 4'h3,
    PH_CU    = 4'h4,
    PH_INIT  = 4'h5,
    PH_USER  = 4'h6,
    PH_ERROR = 4'h7,
    PH_JTAG  = 4'h8
  } pcls_phase_t;

  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE  = 4'h1, TAP_SELDR = 4'h2, TAP_CAPDR = 4'h3,
    TAP_SHDR  = 4'h4, TAP_EX1DR = 4'h5, TAP_PSDR  = 4'h6, TAP_EX2DR = 4'h7,
    TAP_UPDR  = 4'h8, TAP_SELIR = 4'h9, TAP_CAPIR = 4'hA, TAP_SHIR  = 4'hB,
    TAP_EX1IR = 4'hC, TAP_PSIR  = 4'hD, TAP_EX2IR = 4'hE, TAP_UPIR  = 4'hF
  } pcls_tap_t;

  // pins sampled from outside the clock domain
  typedef struct packed {
    logic         req_n;
    logic         bclk;
    logic [7:0]   data;
    logic         uclk;
    logic         tck;
    logic         tms;
    logic         tdi;
    pcls_scheme_t scheme;
  } pcls_pins_t;

  // captured configuration byte
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } pcls_byte_t;

  typedef struct packed {
    pcls_pins_t  s1;
    pcls_pins_t  s2;
    logic        bclk_d;
    logic        uclk_d;
    logic        tck_d;
    pcls_phase_t phase;
    logic [15:0] cnt;
    logic [15:0] bytes;
    logic [1:0]  falls;
    logic [3:0]  as_div;
    logic        as_clk;
    pcls_byte_t  byte_out;
    pcls_tap_t   tap;
    logic [3:0]  ir;
    logic [3:0]  ir_sh;
    logic        dr_sh;
    logic        tdo;
    logic        tdo_oe;
  } pcls_state_t;

  localparam pcls_state_t PCLS_STATE_RST = '0;
endpackage
`default_nettype wire

/* pcls_sequencer.sv */
// pcls_sequencer: byte-wide passive load handshake, init delays and test-port precedence.
// assumes open-drain pins are resolved outside; all pins are asynchronous to ref_clk_i.
// Contract
// - user mode keeps request, status, done high
// - status held low through power-on delay
// - done stays low until load finishes
// - request low pulls done low quickly
// - request low pulls status low quickly; not while the test port holds the program code
// - status low between 45 and 230 us
// - status released within 230 us; after an error with auto-restart off it stays low
// - oscillator init reaches user mode 300-650 us
// - user clock enabled after four byte periods
// - user clock init counts required cycles
// - data bus becomes user I/O afterwards
// - test port load overrides other schemes
// - no byte clock output during test load
// - user pins tri-stated during test load
// - test data sampled on rising test clock
// - test output changes on falling edge
// - test state moves on rising edge
// - bytes captured on byte clock rising edge
// - init complete rises entering user mode
// - auto-restart releases status after time-out
`default_nettype none
module pcls_sequencer #(
  parameter logic [15:0] LOAD_BYTES      = 16'h0100,
  parameter logic [15:0] USER_OSC_LAST   = 16'(pcls_pkg::USER_OSC_CYC - 1),
  parameter logic [15:0] INIT_UCLK_EDGES = 16'h0C00
) (
  // clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  reset_n_i,
  // load handshake pins
  input  wire logic                  config_request_n_i,
  input  wire logic                  config_byte_clock_i,
  output logic                       config_byte_clock_o,
  output logic                       config_byte_clock_oe_o,
  input  wire logic [7:0]            config_data_bus_i,
  output logic                       status_error_n_o,
  output logic                       status_error_n_oe_o,
  output logic                       load_complete_o,
  output logic                       load_complete_oe_o,
  output logic                       init_complete_o,
  output logic                       init_complete_oe_o,
  // options and init clock
  input  wire pcls_pkg::pcls_scheme_t scheme_select_i,
  input  wire logic                  user_init_clock_i,
  input  wire logic                  init_clock_select_i,
  input  wire logic                  auto_restart_i,
  input  wire logic                  dual_purpose_drive_i,
  input  wire logic                  config_error_i,
  // captured bytes and user mode
  output pcls_pkg::pcls_byte_t       config_byte_o,
  output logic                       user_mode_o,
  output logic                       user_io_enable_o,
  output logic                       config_data_bus_oe_o,
  // test port
  input  wire logic                  tck_i,
  input  wire logic                  tms_i,
  input  wire logic                  tdi_i,
  output logic                       tdo_o,
  output logic                       tdo_oe_o
);
  import pcls_pkg::*;

  pcls_state_t state_reg;
  pcls_state_t state_next;

  function automatic pcls_tap_t tap_step(input pcls_tap_t s, input logic tms);
    pcls_tap_t t;
    t = TAP_RESET;
    case (s)
      TAP_RESET: t = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE:  t = tms ? TAP_SELDR : TAP_IDLE;
      TAP_SELDR: t = tms ? TAP_SELIR : TAP_CAPDR;
      TAP_CAPDR: t = tms ? TAP_EX1DR : TAP_SHDR;
      TAP_SHDR:  t = tms ? TAP_EX1DR : TAP_SHDR;
      TAP_EX1DR: t = tms ? TAP_UPDR  : TAP_PSDR;
      TAP_PSDR:  t = tms ? TAP_EX2DR : TAP_PSDR;
      TAP_EX2DR: t = tms ? TAP_UPDR  : TAP_SHDR;
      TAP_UPDR:  t = tms ? TAP_SELDR : TAP_IDLE;
      TAP_SELIR: t = tms ? TAP_RESET : TAP_CAPIR;
      TAP_CAPIR: t = tms ? TAP_EX1IR : TAP_SHIR;
      TAP_SHIR:  t = tms ? TAP_EX1IR : TAP_SHIR;
      TAP_EX1IR: t = tms ? TAP_UPIR  : TAP_PSIR;
      TAP_PSIR:  t = tms ? TAP_EX2IR : TAP_PSIR;
      TAP_EX2IR: t = tms ? TAP_UPIR  : TAP_SHIR;
      TAP_UPIR:  t = tms ? TAP_SELDR : TAP_IDLE;
      default:   t = TAP_RESET;
    endcase
    return t;
  endfunction

  pcls_pins_t  pins;
  logic        req_low;
  logic        bclk_rise;
  logic        bclk_fall;
  logic        uclk_rise;
  logic        tck_rise;
  logic        tck_fall;
  logic        jtag_cfg;
  logic [15:0] load_target;
  logic        status_low;
  logic        done_high;

  always_comb begin
    pins.req_n  = config_request_n_i;
    pins.bclk   = config_byte_clock_i;
    pins.data   = config_data_bus_i;
    pins.uclk   = user_init_clock_i;
    pins.tck    = tck_i;
    pins.tms    = tms_i;
    pins.tdi    = tdi_i;
    pins.scheme = scheme_select_i;
  end

  always_comb begin
    state_next = state_reg;
    // two-stage synchroniser; only the second stage is used below
    state_next.s1     = pins;
    state_next.s2     = state_reg.s1;
    state_next.bclk_d = state_reg.s2.bclk;
    state_next.uclk_d = state_reg.s2.uclk;
    state_next.tck_d  = state_reg.s2.tck;
    state_next.byte_out.valid = 1'b0;

    req_low   = ~state_reg.s2.req_n;
    bclk_rise = state_reg.s2.bclk & ~state_reg.bclk_d;
    bclk_fall = ~state_reg.s2.bclk & state_reg.bclk_d;
    uclk_rise = state_reg.s2.uclk & ~state_reg.uclk_d;
    tck_rise  = state_reg.s2.tck & ~state_reg.tck_d;
    tck_fall  = ~state_reg.s2.tck & state_reg.tck_d;
    jtag_cfg  = (state_reg.ir == IR_PROGRAM);
    // parallel load finishes one byte early
    load_target = (state_reg.s2.scheme == PCLS_PARALLEL) ? LOAD_BYTES - 16'h0001 : LOAD_BYTES;

    if (tck_rise) begin
      state_next.tap = tap_step(state_reg.tap, state_reg.s2.tms);
      case (state_reg.tap)
        TAP_RESET: state_next.ir = IR_BYPASS;
        TAP_CAPIR: state_next.ir_sh = IR_CAPTURE;
        TAP_SHIR:  state_next.ir_sh = {state_reg.s2.tdi, state_reg.ir_sh[3:1]};
        TAP_CAPDR: state_next.dr_sh = 1'b0;
        TAP_SHDR:  state_next.dr_sh = state_reg.s2.tdi;
        TAP_UPIR:  state_next.ir = state_reg.ir_sh;
        default:   state_next.ir = state_reg.ir;
      endcase
    end
    if (tck_fall) begin
      state_next.tdo    = (state_reg.tap == TAP_SHIR) ? state_reg.ir_sh[0] : state_reg.dr_sh;
      state_next.tdo_oe = (state_reg.tap == TAP_SHIR) || (state_reg.tap == TAP_SHDR);
    end

    // active serial clock divider
    if (state_reg.as_div == AS_HALF_LAST) begin
      state_next.as_div = 4'h0;
      state_next.as_clk = ~state_reg.as_clk;
    end else begin
      state_next.as_div = state_reg.as_div + 4'h1;
    end

    case (state_reg.phase)
      PH_POR: begin
        if (state_reg.cnt != STATUS_LOW_LAST) begin
          state_next.cnt = state_reg.cnt + 16'h0001;
        end else if (!req_low) begin
          state_next.phase = PH_LOAD;
          state_next.cnt   = 16'h0000;
          state_next.bytes = 16'h0000;
        end
      end
      // status low pulse, stretched by host
      PH_RESET: begin
        if (req_low) begin
          state_next.cnt = 16'h0000;
        end else if (state_reg.cnt != STATUS_LOW_LAST) begin
          state_next.cnt = state_reg.cnt + 16'h0001;
        end else begin
          state_next.phase = PH_LOAD;
          state_next.cnt   = 16'h0000;
          state_next.bytes = 16'h0000;
        end
      end
      PH_LOAD: begin
        if (config_error_i) begin
          state_next.phase = PH_ERROR;
          state_next.cnt   = 16'h0000;
        end else if (bclk_rise) begin
          state_next.byte_out.valid = 1'b1;
          state_next.byte_out.data  = state_reg.s2.data;
          state_next.bytes          = state_reg.bytes + 16'h0001;
          if (state_reg.bytes + 16'h0001 >= load_target) begin
            state_next.phase = PH_DONE;
            state_next.falls = 2'h0;
          end
        end
      end
      PH_DONE: begin
        if (bclk_fall) begin
          state_next.falls = state_reg.falls + 2'h1;
          if (state_reg.falls + 2'h1 == DONE_FALL_EDGES) begin
            state_next.phase = PH_CU;
            state_next.cnt   = 16'h0000;
          end
        end
      end
      PH_CU: begin
        if (!init_clock_select_i) begin
          state_next.phase = PH_INIT;
        end else if (state_reg.cnt != CD2CU_LAST) begin
          state_next.cnt = state_reg.cnt + 16'h0001;
        end else begin
          state_next.phase = PH_INIT;
          state_next.cnt   = 16'h0000;
        end
      end
      PH_INIT: begin
        if (init_clock_select_i) begin
          if (uclk_rise) begin
            state_next.cnt = state_reg.cnt + 16'h0001;
            if (state_reg.cnt + 16'h0001 == INIT_UCLK_EDGES) begin
              state_next.phase = PH_USER;
            end
          end
        end else if (state_reg.cnt != USER_OSC_LAST) begin
          state_next.cnt = state_reg.cnt + 16'h0001;
        end else begin
          state_next.phase = PH_USER;
        end
      end
      PH_USER: begin
        state_next.cnt = 16'h0000;
      end
      PH_ERROR: begin
        if (auto_restart_i) begin
          if (state_reg.cnt != STATUS_LOW_LAST) begin
            state_next.cnt = state_reg.cnt + 16'h0001;
          end else begin
            state_next.phase = PH_LOAD;
            state_next.cnt   = 16'h0000;
            state_next.bytes = 16'h0000;
          end
        end
      end
      PH_JTAG: begin
        if (!jtag_cfg) begin
          state_next.phase = PH_DONE;
          state_next.falls = DONE_FALL_EDGES - 2'h1;
        end
      end
      default: begin
        state_next.phase = PH_POR;
        state_next.cnt   = 16'h0000;
      end
    endcase

    if (req_low && (state_reg.phase != PH_POR) && (state_reg.phase != PH_JTAG)) begin
      state_next.phase = PH_RESET;
      state_next.cnt   = 16'h0000;
    end
    if (jtag_cfg && (state_reg.phase != PH_POR)) begin
      state_next.phase = PH_JTAG;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= PCLS_STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign status_low = (state_reg.phase == PH_POR) || (state_reg.phase == PH_RESET)
                   || (state_reg.phase == PH_ERROR);
  assign done_high  = (state_reg.phase == PH_DONE) || (state_reg.phase == PH_CU)
                   || (state_reg.phase == PH_INIT) || (state_reg.phase == PH_USER);

  // open-drain lines: low when enabled, released otherwise
  assign status_error_n_o    = 1'b0;
  assign status_error_n_oe_o = status_low;
  assign load_complete_o     = 1'b0;
  // done pulled low outside done phases
  assign load_complete_oe_o  = ~done_high;
  assign init_complete_o     = 1'b0;
  assign init_complete_oe_o  = (state_reg.phase != PH_USER);

  // no clock drive during test load
  assign config_byte_clock_o    = state_reg.as_clk;
  assign config_byte_clock_oe_o = (state_reg.s2.scheme == PCLS_ACTIVE) && (state_reg.phase == PH_LOAD)
                                  && !jtag_cfg;

  assign config_byte_o = state_reg.byte_out;
  assign user_mode_o   = (state_reg.phase == PH_USER);
  // user pins tri-stated in test load
  assign user_io_enable_o     = (state_reg.phase == PH_USER) && !jtag_cfg;
  assign config_data_bus_oe_o = user_io_enable_o && dual_purpose_drive_i;

  assign tdo_o    = state_reg.tdo;
  assign tdo_oe_o = state_reg.tdo_oe;
endmodule
`default_nettype wire

/* pcls_dummy_end.sv */
`default_nettype none
`default_nettype wire

/* pcls_seq_asserts.sv */
// pcls_seq_asserts: pin timing checks on the config-load sequencer.
// assumes open-drain lines are modelled as an enable that pulls the line low.
`default_nettype none
module pcls_seq_asserts (
  // clock and reset
  input wire logic                 ref_clk_i,
  input wire logic                 reset_n_i,
  // watched pins
  input wire logic                 config_request_n_i,
  input wire logic                 dual_purpose_drive_i,
  input wire logic                 tck_i,
  input wire logic                 status_error_n_oe_o,
  input wire logic                 load_complete_oe_o,
  input wire logic                 init_complete_oe_o,
  input wire logic                 config_byte_clock_oe_o,
  input wire pcls_pkg::pcls_byte_t config_byte_o,
  input wire logic                 user_mode_o,
  input wire logic                 user_io_enable_o,
  input wire logic                 config_data_bus_oe_o,
  input wire logic                 tdo_o,
  input wire logic                 tdo_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import pcls_pkg::*;
  localparam int ST_MIN = STATUS_LOW_CYC - 2;
  localparam int ST_MAX = 11500;
  logic [15:0] st_cnt;
  logic [15:0] dn_cnt;
  // cycles of status low with request high, and cycles since done
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_cnt <= '0;
      dn_cnt <= '0;
    end else begin
      st_cnt <= (status_error_n_oe_o && config_request_n_i) ? st_cnt + 16'h0001 : '0;
      dn_cnt <= load_complete_oe_o ? '0 : dn_cnt + 16'(dn_cnt != 16'hFFFF);
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_user_lines_high: assert property (user_mode_o |-> !load_complete_oe_o && !status_error_n_oe_o)
    else $error("lines low in user mode");
  a_req_pulls_low: assert property ($fell(config_request_n_i) |-> ##[1:25] (load_complete_oe_o && status_error_n_oe_o))
    else $error("request low not answered in time");
  a_status_min: assert property ($fell(status_error_n_oe_o) |-> st_cnt >= ST_MIN)
    else $error("status released too early");
  a_status_max: assert property (status_error_n_oe_o |-> st_cnt <= ST_MAX)
    else $error("status held low too long");
  a_no_late_byte: assert property (!load_complete_oe_o && $past(!load_complete_oe_o) |-> !config_byte_o.valid)
    else $error("byte taken after done");
  a_valid_single: assert property (config_byte_o.valid |=> !config_byte_o.valid [*2])
    else $error("byte valid too long");
  a_init_delay: assert property ($rose(user_mode_o) |-> dn_cnt >= CD2CU_CYC)
    else $error("user mode too soon after done");
  a_init_flag: assert property ($rose(user_mode_o) |-> $fell(init_complete_oe_o))
    else $error("init flag not released with user mode");
  a_bus_user_io: assert property (config_data_bus_oe_o |-> user_io_enable_o && user_mode_o && dual_purpose_drive_i)
    else $error("data bus driven outside user mode");
  a_bclk_in_load: assert property (config_byte_clock_oe_o |-> load_complete_oe_o && !user_mode_o)
    else $error("byte clock driven outside load");
  a_tdo_on_fall: assert property (($changed(tdo_o) || $changed(tdo_oe_o)) |-> !tck_i)
    else $error("test output moved with test clock high");
  c_user: cover property ($rose(user_mode_o));
  c_done: cover property ($fell(load_complete_oe_o));
  c_shift: cover property ($rose(tdo_oe_o));
endmodule
bind pcls_sequencer pcls_seq_asserts u_chk (.ref_clk_i, .reset_n_i, .config_request_n_i, .dual_purpose_drive_i,
  .tck_i, .status_error_n_oe_o, .load_complete_oe_o, .init_complete_oe_o, .config_byte_clock_oe_o,
  .config_byte_o, .user_mode_o, .user_io_enable_o, .config_data_bus_oe_o, .tdo_o, .tdo_oe_o);
`default_nettype wire

/* pcls_host_model.sv */
// pcls_host_model: byte-wide host feeding configuration bytes.
// assumes the bench hands in resolved line levels; notes each byte it sends.
`default_nettype none
module pcls_host_model (
  // line levels
  input  wire logic       req_line_i,
  input  wire logic       status_line_i,
  input  wire logic       done_line_i,
  // driven pins
  output logic            bclk_o,
  output logic [7:0]      data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] exp_q[$];
  realtime    t_req = -1.0e6;
  always @(posedge req_line_i) t_req = $realtime;
  initial begin
    bclk_o = 1'b0;
    data_o = 8'h00;
  end
  task automatic send(input int max);
    int i;
    i = 0;
    wait (status_line_i === 1'b1);
    #2007;
    // first byte clock no sooner than 230 us after the request rose
    if ($realtime - t_req < 230000.0)
      #(230007.0 - ($realtime - t_req));
    while (done_line_i !== 1'b1 && i < max) begin
      data_o = 8'($urandom);
      exp_q.push_back(data_o);
      #80 bclk_o = 1'b1;
      #80 bclk_o = 1'b0;
      data_o = ~data_o;
      i++;
    end
  endtask
  task automatic finish(input int falls);
    #7;
    repeat (falls) begin
      #80 bclk_o = 1'b1;
      data_o = ~data_o;
      #80 bclk_o = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* test_parallel_config_load_sequencer.sv */
// test_parallel_config_load_sequencer: power-up, loads, reconfig, error retry, test-port takeover.
// assumes pull-ups on the open-drain lines; the host model drives byte clock and data.
`default_nettype none
module test_parallel_config_load_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import pcls_pkg::*;
  localparam logic [15:0] NB  = 16'h0004;
  localparam logic [15:0] OSC = 16'h0020;
  localparam logic [10:0] TMS_S = 11'h306, TDI_S = 11'h040, OE_S = 11'h0F0, TDO_S = 11'h010;
  logic ref_clk_i, reset_n_i, req_n, isel, dpd, cerr, tck, tms, tdi, hbclk, bclk_o, bclk_oe;
  logic st_oe, lc_oe, ic_oe, umode, uio, dbus_oe, tdo, tdo_oe, oe, o, arst, st_o, lc_o, ic_o;
  logic [7:0]   hdata;
  logic [2:0]   ucnt = 3'h0;
  pcls_scheme_t scheme;
  pcls_byte_t   cbyte;
  int error_cnt = 0, samples_checked = 0, got_n = 0, cycles = 0, n;
  pcls_sequencer #(.LOAD_BYTES(NB), .USER_OSC_LAST(OSC), .INIT_UCLK_EDGES(16'h0004)) dut (
    .ref_clk_i, .reset_n_i, .config_request_n_i(req_n), .config_byte_clock_i(bclk_oe ? bclk_o : hbclk),
    .config_byte_clock_o(bclk_o), .config_byte_clock_oe_o(bclk_oe), .config_data_bus_i(hdata),
    .status_error_n_o(st_o), .status_error_n_oe_o(st_oe), .load_complete_o(lc_o), .load_complete_oe_o(lc_oe),
    .init_complete_o(ic_o), .init_complete_oe_o(ic_oe), .scheme_select_i(scheme), .user_init_clock_i(ucnt[2]),
    .init_clock_select_i(isel), .auto_restart_i(arst), .dual_purpose_drive_i(dpd), .config_error_i(cerr),
    .config_byte_o(cbyte), .user_mode_o(umode), .user_io_enable_o(uio), .config_data_bus_oe_o(dbus_oe),
    .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe));
  pcls_host_model host (.req_line_i(req_n), .status_line_i(!st_oe), .done_line_i(!lc_oe), .bclk_o(hbclk),
    .data_o(hdata));
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk_i);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_on(input int which, output int k);
    k = 0;
    while (!((which == 0 && umode === 1'b1) || (which == 1 && st_oe === 1'b0)) && k < 15000) begin
      cyc(1);
      k++;
    end
  endtask
  task automatic req_pulse();
    req_n <= 1'b0;
    cyc(25);
    chk({lc_oe, st_oe, umode}, 16'h0006);
    cyc(5);
    req_n <= 1'b1;
    wait_on(1, n);
    chk(16'(n >= STATUS_LOW_CYC && n <= 11500), 16'h0001);
  endtask
  task automatic tap(input logic m, input logic d);
    tms <= m;
    tdi <= d;
    cyc(6);
    tck <= 1'b1;
    cyc(6);
    tck <= 1'b0;
    cyc(8);
    oe = tdo_oe;
    o = tdo;
  endtask
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    ucnt <= ucnt + 3'h1;
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      complete_run();
    end
  end
  always @(posedge ref_clk_i) begin
    if (cbyte.valid === 1'b1) begin
      got_n++;
      if (host.exp_q.size() == 0)
        chk(16'h0001, 16'h0000);
      else
        chk({8'h00, cbyte.data}, {8'h00, host.exp_q.pop_front()});
    end
  end
  initial begin
    void'($urandom(48));
    {reset_n_i, cerr, tck, tdi} = '0;
    {req_n, isel, tms, arst} = '1;
    dpd = 1'($urandom);
    scheme = PCLS_PARALLEL;
    cyc(2);
    reset_n_i <= 1'b1;
    cyc(2000);
    chk({st_oe, lc_oe}, 16'h0003);
    chk({st_o, lc_o, ic_o}, 16'h0000);
    wait_on(1, n);
    chk(16'(n >= 240 && n <= 300), 16'h0001);
    $display("power-up test done");
    host.send(16);
    chk(16'(got_n), NB - 16'h0001);
    host.finish(2);
    wait_on(0, n);
    chk(16'(n + 16 >= CD2CU_CYC), 16'h0001);
    chk({ic_oe, uio, dbus_oe}, {13'h0, 1'b0, 1'b1, dpd});
    $display("parallel load test done");
    scheme <= PCLS_PASSIVE;
    isel <= 1'b0;
    req_pulse();
    arst <= 1'b0;
    cerr <= 1'b1;
    cyc(1);
    cerr <= 1'b0;
    cyc(4);
    chk(st_oe, 16'h0001);
    // without auto-restart the status line stays low past the time-out
    cyc(2400);
    chk(st_oe, 16'h0001);
    arst <= 1'b1;
    wait_on(1, n);
    chk(16'(n >= 2240 && n <= 11500), 16'h0001);
    got_n = 0;
    host.send(16);
    chk(16'(got_n), NB);
    host.finish(2);
    wait_on(0, n);
    chk(16'(n + 16 > OSC && n <= 100), 16'h0001);
    $display("reconfig and retry test done");
    req_pulse();
    host.send(1);
    // load program code into the test port
    for (int i = 0; i < 11; i++) begin
      tap(TMS_S[i], TDI_S[i]);
      chk(oe, OE_S[i]);
      if (OE_S[i])
        chk(o, TDO_S[i]);
    end
    scheme <= PCLS_ACTIVE;
    cyc(8);
    chk({bclk_oe, uio, umode}, 16'h0000);
    for (int i = 0; i < 5; i++)
      tap(1'b1, 1'b0);
    scheme <= PCLS_PASSIVE;
    host.finish(1);
    wait_on(0, n);
    chk(umode, 16'h0001);
    $display("test port takeover done");
    complete_run();
  end
endmodule
`default_nettype wire
